//--- rtl/ptev_pkg.sv
// Constants shared by the pin task and event channel block.
// Assumes a 200 MHz APB clock and a 12-bit byte address on the bus.
package ptev_pkg;

	// ==========================================================================
	// Sizes.
	localparam int NUM_CH = 4;
	localparam int NUM_PIN = 32;
	localparam int ADDR_W = 12;

	// ==========================================================================
	// Register byte offsets.
	localparam logic [11:0] CFG_BASE_OFF = 12'h51C;
	localparam logic [11:0] CH4_CFG_OFF = 12'h520;
	localparam logic [11:0] CH5_CFG_OFF = 12'h524;
	localparam logic [11:0] CH6_CFG_OFF = 12'h528;
	localparam logic [11:0] TASK_OUT_OFF = 12'h000;
	localparam logic [11:0] TASK_SET_OFF = 12'h030;
	localparam logic [11:0] TASK_CLR_OFF = 12'h060;
	localparam logic [11:0] EVT_STAT_OFF = 12'h100;
	localparam logic [11:0] INTENSET_OFF = 12'h304;
	localparam logic [11:0] INTENCLR_OFF = 12'h308;

	// ==========================================================================
	// Channel configuration fields.
	localparam int MODE_LSB = 0;
	localparam int PSEL_LSB = 8;
	localparam int ACT_LSB = 16;
	localparam int INIT_BIT = 20;
	localparam logic [31:0] CFG_MASK = 32'h0013_1F03;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;

	// Mode and action encodings.
	localparam logic [1:0] MODE_DIS = 2'h0;
	localparam logic [1:0] MODE_EVT = 2'h1;
	localparam logic [1:0] MODE_TASK = 2'h3;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] RISING_ACTION = 2'h1;
	localparam logic [1:0] FALLING_ACTION = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	// ==========================================================================
	// Reset values of the remaining state.
	localparam logic [3:0] CH_RESET = 4'h0;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

endpackage

//--- rtl/ptev_channels.sv
// Four pin task and event channels (channels 3 to 6) with an APB slave.
// Assumes pin inputs are asynchronous, GPIO port outputs and task strobes
// come from logic on pclk, and the bus master follows APB signalling.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps

module ptev_channels (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] pin_in,
	input wire logic [31:0] gpio_out,
	input wire logic [31:0] gpio_oe,
	input wire logic [3:0] task_set_in,
	input wire logic [3:0] drive_low_task_in,
	input wire logic [3:0] task_out_in,
	output logic [31:0] pin_out,
	output logic [31:0] pin_oe,
	output logic [3:0] event_pulse,
	output logic irq
);

	// ==========================================================================
	// Helper functions.

	// True when the address falls on one of the four config words.
	function automatic logic is_cfg(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - ptev_pkg::CFG_BASE_OFF;
		return (rel[1:0] == 2'h0) && (rel[11:4] == 8'h00);
	endfunction

	// Slot 0..3 of a config address.
	function automatic logic [1:0] cfg_slot(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - ptev_pkg::CFG_BASE_OFF;
		return rel[3:2];
	endfunction

	// Edge qualification for event mode.
	function automatic logic edge_hit(input logic [1:0] act, input logic rise,
			input logic fall);
		logic hit;
		hit = 1'b0;
		unique case (act)
			ptev_pkg::ACT_NONE: hit = 1'b0;
			ptev_pkg::RISING_ACTION: hit = rise;
			ptev_pkg::FALLING_ACTION: hit = fall;
			ptev_pkg::ACT_TOGGLE: hit = rise | fall;
		endcase
		return hit;
	endfunction

	// Pin operation of the polarity-action task in task mode.
	function automatic logic act_apply(input logic [1:0] act, input logic lvl);
		logic res;
		res = lvl;
		unique case (act)
			ptev_pkg::ACT_NONE: res = lvl;
			ptev_pkg::RISING_ACTION: res = 1'b1;
			ptev_pkg::FALLING_ACTION: res = 1'b0;
			ptev_pkg::ACT_TOGGLE: res = ~lvl;
		endcase
		return res;
	endfunction

	// ==========================================================================
	// State.
	logic [31:0] cfg_r [4];
	logic [31:0] sync1_r;
	logic [31:0] sync2_r;
	logic [31:0] prev_r;
	logic [3:0] level_r;
	logic [3:0] level_nxt;
	logic [3:0] evt_stat_r;
	logic [3:0] inten_r;
	logic [3:0] hit_nxt;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] rd_nxt;
	logic rd_ok;
	logic [31:0] pin_out_r;
	logic [31:0] pin_oe_r;
	logic [31:0] pout_nxt;
	logic [31:0] poe_nxt;
	logic [3:0] event_pulse_r;
	logic irq_r;

	logic setup_ph;
	logic wr_en;
	logic [3:0] wdat4;
	logic [3:0] t_set;
	logic [3:0] t_clr;
	logic [3:0] t_out;

	// ==========================================================================
	// APB decode. The slave answers in the first access cycle; a write takes
	// effect on the edge that samples pready high.
	// Limitation: pce must stay high across an access cycle. A master that
	// sees pready while the block is frozen would end the transfer, and the
	// write would never be taken.
	assign setup_ph = psel & ~penable;
	assign wr_en = psel & penable & pready_r & pwrite;
	assign wdat4 = pwdata[3:0];

	// Register and pin-strobe task triggers merged per channel.
	assign t_set = task_set_in | ((wr_en && paddr == ptev_pkg::TASK_SET_OFF) ? wdat4 : 4'h0);
	assign t_clr = drive_low_task_in |
		((wr_en && paddr == ptev_pkg::TASK_CLR_OFF) ? wdat4 : 4'h0);
	assign t_out = task_out_in | ((wr_en && paddr == ptev_pkg::TASK_OUT_OFF) ? wdat4 : 4'h0);

	// Read data mux; task registers are write-only and read as zero.
	always_comb begin
		rd_nxt = ptev_pkg::WORD_RESET;
		rd_ok = 1'b1;
		if (is_cfg(paddr)) begin
			rd_nxt = cfg_r[cfg_slot(paddr)];
		end else begin
			case (paddr)
				ptev_pkg::TASK_OUT_OFF,
				ptev_pkg::TASK_SET_OFF,
				ptev_pkg::TASK_CLR_OFF: rd_nxt = ptev_pkg::WORD_RESET;
				ptev_pkg::EVT_STAT_OFF: rd_nxt = {28'h0000000, evt_stat_r};
				ptev_pkg::INTENSET_OFF,
				ptev_pkg::INTENCLR_OFF: rd_nxt = {28'h0000000, inten_r};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// Bus answer registers: pready rises for exactly the first access cycle.
	// Read data is captured at the setup edge and stands until the next setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= ptev_pkg::WORD_RESET;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (pce) begin
			pready_r <= setup_ph;
			if (setup_ph) begin
				prdata_r <= pwrite ? ptev_pkg::WORD_RESET : rd_nxt;
				pslverr_r <= ~rd_ok;
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Configuration registers; reserved bits are masked off so they read zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < ptev_pkg::NUM_CH; i++) begin
				cfg_r[i] <= ptev_pkg::CFG_RESET;
			end
		end else if (pce) begin
			if (wr_en && is_cfg(paddr)) begin
				cfg_r[cfg_slot(paddr)] <= pwdata & ptev_pkg::CFG_MASK;
			end
		end
	end

	// ==========================================================================
	// Pin input synchroniser and previous-sample store for edge detection.
	// Only sync2_r and prev_r are looked at, never the first stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= ptev_pkg::WORD_RESET;
			sync2_r <= ptev_pkg::WORD_RESET;
			prev_r <= ptev_pkg::WORD_RESET;
		end else if (pce) begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// Event detection on the selected pin. Changing the pin select while in
	// event mode may see a false edge; software should disable first.
	always_comb begin
		logic [4:0] p;
		logic [1:0] md;
		p = 5'h00;
		md = ptev_pkg::MODE_DIS;
		hit_nxt = ptev_pkg::CH_RESET;
		for (int i = 0; i < ptev_pkg::NUM_CH; i++) begin
			p = cfg_r[i][ptev_pkg::PSEL_LSB +: 5];
			md = cfg_r[i][ptev_pkg::MODE_LSB +: 2];
			if (md == ptev_pkg::MODE_EVT) begin
				hit_nxt[i] = edge_hit(cfg_r[i][ptev_pkg::ACT_LSB +: 2],
					sync2_r[p] & ~prev_r[p], ~sync2_r[p] & prev_r[p]);
			end
		end
	end

	// Event pulses and sticky status; a new event beats a same-cycle clear.
	// Status bits keep their record even while the interrupt is disabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_pulse_r <= ptev_pkg::CH_RESET;
			evt_stat_r <= ptev_pkg::CH_RESET;
		end else if (pce) begin
			event_pulse_r <= hit_nxt;
			if (wr_en && paddr == ptev_pkg::EVT_STAT_OFF) begin
				evt_stat_r <= (evt_stat_r & ~wdat4) | hit_nxt;
			end else begin
				evt_stat_r <= evt_stat_r | hit_nxt;
			end
		end
	end

	// Interrupt enables: write one to set, write one to clear.
	// Both addresses read back the same enable bits, so software can check
	// either one after a change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inten_r <= ptev_pkg::CH_RESET;
		end else if (pce) begin
			if (wr_en && paddr == ptev_pkg::INTENSET_OFF) begin
				inten_r <= inten_r | wdat4;
			end else if (wr_en && paddr == ptev_pkg::INTENCLR_OFF) begin
				inten_r <= inten_r & ~wdat4;
			end
		end
	end

	// Level interrupt, high while an enabled status bit stands.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else if (pce) begin
			irq_r <= |(evt_stat_r & inten_r);
		end
	end

	// ==========================================================================
	// Task-mode output levels. A config write that selects task mode loads the
	// initial level and masks tasks in that cycle; otherwise set, then clear,
	// then the polarity action apply in that order when fired together.
	// Rewriting the config of a channel already in task mode reloads the
	// initial level as well, which is a cheap way to force the pin.
	always_comb begin
		logic lv;
		lv = 1'b0;
		level_nxt = level_r;
		for (int i = 0; i < ptev_pkg::NUM_CH; i++) begin
			lv = level_r[i];
			if (wr_en && is_cfg(paddr) && cfg_slot(paddr) == 2'(i) &&
					pwdata[ptev_pkg::MODE_LSB +: 2] == ptev_pkg::MODE_TASK) begin
				lv = pwdata[ptev_pkg::INIT_BIT];
			end else if (cfg_r[i][ptev_pkg::MODE_LSB +: 2] == ptev_pkg::MODE_TASK) begin
				if (t_set[i]) begin
					lv = 1'b1;
				end
				if (t_clr[i]) begin
					lv = 1'b0;
				end
				if (t_out[i]) begin
					lv = act_apply(cfg_r[i][ptev_pkg::ACT_LSB +: 2], lv);
				end
			end
			level_nxt[i] = lv;
		end
	end

	// Channel output level store.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= ptev_pkg::CH_RESET;
		end else if (pce) begin
			level_r <= level_nxt;
		end
	end

	// ==========================================================================
	// Pin ownership. Disabled channels leave the port value alone; event mode
	// turns the pin into an input; task mode takes the pin over. When two
	// channels pick the same pin the higher channel wins.
	// The port enable passes through untouched for pins that no channel
	// claims, so the port block stays in charge of them.
	always_comb begin
		logic [4:0] p;
		logic [1:0] md;
		p = 5'h00;
		md = ptev_pkg::MODE_DIS;
		pout_nxt = gpio_out;
		poe_nxt = gpio_oe;
		for (int i = 0; i < ptev_pkg::NUM_CH; i++) begin
			p = cfg_r[i][ptev_pkg::PSEL_LSB +: 5];
			md = cfg_r[i][ptev_pkg::MODE_LSB +: 2];
			if (md == ptev_pkg::MODE_TASK) begin
				pout_nxt[p] = level_r[i];
				poe_nxt[p] = 1'b1;
			end else if (md == ptev_pkg::MODE_EVT) begin
				poe_nxt[p] = 1'b0;
			end
		end
	end

	// Registered pin drivers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out_r <= ptev_pkg::WORD_RESET;
			pin_oe_r <= ptev_pkg::WORD_RESET;
		end else if (pce) begin
			pin_out_r <= pout_nxt;
			pin_oe_r <= poe_nxt;
		end
	end

	// ==========================================================================
	// Outputs, all straight from flip-flops.
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pin_out = pin_out_r;
	assign pin_oe = pin_oe_r;
	assign event_pulse = event_pulse_r;
	assign irq = irq_r;

endmodule

//--- sim/ptev_asserts.sv
// Checker for the pin task and event channel block, bound to its top module.
// Assumes it sees only the top module's ports, on one clock domain.
`timescale 1ns/100ps
module ptev_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] pin_in,
	input wire logic [31:0] gpio_out,
	input wire logic [31:0] gpio_oe,
	input wire logic [3:0] task_set_in,
	input wire logic [3:0] drive_low_task_in,
	input wire logic [3:0] task_out_in,
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [3:0] event_pulse,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] quiet_r;

	// =====
	// Calm cycles: no bus, no task, no port change. Pins may only move after a cause.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_r <= 3'h0;
		end else if (psel || (|task_set_in) || (|drive_low_task_in) || (|task_out_in) ||
			!$stable(gpio_out) || !$stable(gpio_oe)) begin
			quiet_r <= 3'h0;
		end else if (quiet_r != 3'h7) begin
			quiet_r <= quiet_r + 3'h1;
		end
	end

	// =====
	// Bus answer, events, interrupt and pin ownership.
	a_ready_setup: assert property (psel && !penable && pce |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready && pce |=> !pready)
		else $error("ready held too long");
	a_err_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("refused read with data");
	a_rdata_hold: assert property (!psel && !$past(psel) |-> $stable(prdata))
		else $error("read data moved while idle");
	a_evt_edge: assert property (|event_pulse |-> $past(pin_in, 3) != $past(pin_in, 4))
		else $error("event without pin edge");
	a_irq_rise: assert property ($rose(irq) |->
		(|$past(event_pulse)) || ($past(pready, 2) && $past(pwrite, 2)))
		else $error("interrupt without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(pready, 2) && $past(pwrite, 2))
		else $error("interrupt dropped without write");
	a_pin_quiet: assert property (quiet_r >= 3'h3 |->
		$stable(pin_out) && $stable(pin_oe))
		else $error("pin moved without cause");
	c_event: cover property (|event_pulse);
	c_refused: cover property (pslverr);
	c_irq_clear: cover property ($fell(irq));
endmodule

bind ptev_channels ptev_asserts u_chk (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .prdata,
	.pready, .pslverr, .pin_in, .gpio_out, .gpio_oe, .task_set_in, .drive_low_task_in,
	.task_out_in, .pin_out, .pin_oe, .event_pulse, .irq);

//--- sim/ptev_pin_pad.sv
// Model of the pads and the outside signals on the 32 general purpose pins.
// Assumes the bench sets the outside level of each pin that the block leaves free.
`timescale 1ns/100ps
module ptev_pin_pad (
	input wire logic [31:0] ext_lvl,
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	output logic [31:0] pin_in
);
	// A driven pin reads back its own level; a free pin shows the outside source.
	assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

//--- sim/tb.sv
// Self-checking bench for the pin task and event channel block.
// Assumes the pad model feeds the pins and APB runs on pclk.
`timescale 1ns/100ps
module tb;
	logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, gpio_out, gpio_oe, pin_in, pin_out, pin_oe, ext_lvl, q;
	logic [3:0] task_set_in, drive_low_task_in, task_out_in, event_pulse;
	int fails, num_checks, ecnt;

	ptev_channels dut (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pin_in, .gpio_out, .gpio_oe, .task_set_in, .drive_low_task_in,
		.task_out_in, .pin_out, .pin_oe, .event_pulse, .irq);
	ptev_pin_pad pad (.ext_lvl, .pin_out, .pin_oe, .pin_in);

	// =====
	// Clock at 200 MHz and a counter of channel 4 events.
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) if (event_pulse[1] === 1'b1) ecnt <= ecnt + 1;

	// =====
	// One APB transfer; waits for pready as long as needed, the watchdog ends a dead wait.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			$display("Error %s expected %h seen %h", nm, x, g);
			fails++;
		end
	endtask

	function automatic logic [31:0] cfg(logic [1:0] m, logic [4:0] p, logic [1:0] a, logic i);
		return {11'h0, i, 2'h0, a, 3'h0, p, 6'h0, m};
	endfunction

	// One-cycle strobe: kind 0 set, 1 drive low, 2 polarity action.
	task automatic tsk(input int k, input int b);
		@(posedge pclk);
		if (k == 0) task_set_in <= 4'h1 << b;
		else if (k == 1) drive_low_task_in <= 4'h1 << b;
		else task_out_in <= 4'h1 << b;
		@(posedge pclk);
		task_set_in <= 4'h0;
		drive_low_task_in <= 4'h0;
		task_out_in <= 4'h0;
		repeat (3) @(posedge pclk);
	endtask

	task automatic edge_cnt(input logic lvl, input logic [31:0] x);
		int c0;
		@(posedge pclk);
		c0 = ecnt;
		ext_lvl[9] <= lvl;
		repeat (8) @(posedge pclk);
		chk("event_count", x, 32'(ecnt - c0));
	endtask

	// =====
	// Scenarios.
	task automatic t_regs;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ptev_pkg::CFG_BASE_OFF + 12'(4 * i), 32'h0);
			chk("cfg_reset", 32'h0, q);
		end
		apb(1'b1, ptev_pkg::CH5_CFG_OFF, 32'hFFFF_FFFF);
		apb(1'b0, ptev_pkg::CH5_CFG_OFF, 32'h0);
		chk("cfg_fields", 32'h0013_1F03, q);
		apb(1'b1, ptev_pkg::CH5_CFG_OFF, 32'h0);
		apb(1'b0, 12'h400, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		$display("register test done");
	endtask

	// Port drives every pin low, so a high level proves the channel owns it.
	task automatic t_task;
		logic [1:0] a;
		logic i0;
		logic ex;
		gpio_oe <= 32'hFFFF_FFFF;
		for (int k = 0; k < 4; k++) begin
			a = 2'(k);
			i0 = (a == 2'h2);
			apb(1'b1, ptev_pkg::CFG_BASE_OFF, cfg(2'h3, 5'h05, a, i0));
			repeat (3) @(posedge pclk);
			chk("init_level", {31'h0, i0}, {31'h0, pin_out[5]});
			chk("pin_drive", 32'h1, {31'h0, pin_oe[5]});
			tsk(2, 0);
			ex = (a == 2'h0) ? i0 : (a == 2'h3) ? ~i0 : a[0];
			chk("action", {31'h0, ex}, {31'h0, pin_out[5]});
		end
		tsk(0, 0);
		chk("set_task", 32'h1, {31'h0, pin_out[5]});
		tsk(1, 0);
		chk("low_task", 32'h0, {31'h0, pin_out[5]});
		// The same three tasks fired from their registers.
		apb(1'b1, ptev_pkg::TASK_SET_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk("set_reg", 32'h1, {31'h0, pin_out[5]});
		apb(1'b1, ptev_pkg::TASK_CLR_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk("clr_reg", 32'h0, {31'h0, pin_out[5]});
		apb(1'b1, ptev_pkg::TASK_OUT_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk("out_reg", 32'h1, {31'h0, pin_out[5]});
		// With the clock enable low a drive-low strobe must be lost.
		pce <= 1'b0;
		tsk(1, 0);
		pce <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("frozen", 32'h1, {31'h0, pin_out[5]});
		apb(1'b1, ptev_pkg::CH6_CFG_OFF, cfg(2'h3, 5'h1F, 2'h0, 1'b1));
		apb(1'b1, ptev_pkg::CFG_BASE_OFF, 32'h0);
		gpio_out <= 32'h0000_0020;
		repeat (3) @(posedge pclk);
		chk("pin_select", 32'h1, {31'h0, pin_out[31]});
		chk("released", 32'h1, {31'h0, pin_out[5]});
		apb(1'b1, ptev_pkg::CH6_CFG_OFF, 32'h0);
		gpio_oe <= 32'h0000_0200; // Port keeps driving pin 9 until event mode takes it.
		$display("task test done");
	endtask

	task automatic t_evt;
		logic [1:0] a;
		apb(1'b1, ptev_pkg::INTENSET_OFF, 32'h2);
		for (int k = 0; k < 4; k++) begin
			a = 2'(k);
			apb(1'b1, ptev_pkg::CH4_CFG_OFF, cfg(2'h1, 5'h09, a, 1'b1));
			edge_cnt(1'b1, {31'h0, a[0]});
			chk("irq_set", {31'h0, a[0]}, {31'h0, irq});
			edge_cnt(1'b0, {31'h0, a[1]});
			chk("pin_input", 32'h0, {31'h0, pin_oe[9]});
			apb(1'b1, ptev_pkg::EVT_STAT_OFF, 32'h2);
			repeat (2) @(posedge pclk);
			chk("irq_clear", 32'h0, {31'h0, irq});
		end
		apb(1'b1, ptev_pkg::INTENCLR_OFF, 32'h2);
		apb(1'b0, ptev_pkg::INTENCLR_OFF, 32'h0);
		chk("int_off", 32'h0, q);
		edge_cnt(1'b1, 32'h1);
		chk("irq_masked", 32'h0, {31'h0, irq});
		$display("event test done");
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// =====
	// Main sequence; pce starts high and only t_task drops it, for the lost drive-low strobe check.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{gpio_out, gpio_oe, ext_lvl, task_set_in, drive_low_task_in, task_out_in} = '0;
		pce = 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_task;
		t_evt;
		wrap_up;
	end

	// Tests need a few hundred cycles; 40000 leaves ample margin.
	initial begin
		#200000;
		fails++;
		wrap_up;
	end
endmodule
